// file: include/trace_elem_regs.svh
// Named widths and constants for the program-flow trace element generator.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TRACE_ELEM_REGS_SVH
`define TRACE_ELEM_REGS_SVH

// Width of an instruction or vector address.
`define TE_ADDR_W   32
// Width of a context identifier value.
`define TE_CTX_W    32
// Width of a cancel or commit count.
`define TE_CNT_W    8
// A commit count of this value asks to commit everything outstanding.
`define TE_CNT_ALL  8'h00
// One element added to the uncommitted window.
`define TE_CNT_ONE  8'h01
// Reset value of addresses held in the state.
`define TE_ADDR_RST 32'h0000_0000
// Reset value of context values held in the state.
`define TE_CTX_RST  32'h0000_0000

`endif

// file: include/trace_elem_pkg.sv
// Types shared by the trace element generator and its window counter.
// Assumes the constants header sits on the include path.
`include "trace_elem_regs.svh"

package trace_elem_pkg;

  // Kind of event that the processing element reports in one cycle.
  typedef enum logic [3:0] {
    EV_NONE         = 4'h0,
    EV_START        = 4'h1,
    EV_BR_TAKEN     = 4'h2,
    EV_BR_NOT_TAKEN = 4'h3,
    EV_PLAIN        = 4'h4,
    EV_CTX_WRITE    = 4'h5,
    EV_SYNC_BARRIER = 4'h6,
    EV_CANCEL       = 4'h7,
    EV_ABORT        = 4'h8,
    EV_EXCEPTION    = 4'h9,
    EV_COMMIT       = 4'hA
  } evt_kind_t;

  // One event from the processing element.
  typedef struct packed {
    logic                  valid;   // Event present this cycle.
    evt_kind_t             kind;    // What happened.
    logic [`TE_ADDR_W-1:0] addr;    // Instruction, return or fault address.
    logic [`TE_ADDR_W-1:0] vector;  // Exception vector address.
    logic [`TE_CTX_W-1:0]  ctx;     // Context value carried by the event.
    logic [`TE_CNT_W-1:0]  count;   // Cancel or commit count.
  } evt_t;

  // Kind of trace element sent to the analyser.
  typedef enum logic [3:0] {
    EL_INFO      = 4'h0,
    EL_ON        = 4'h1,
    EL_CONTEXT   = 4'h2,
    EL_ADDRESS   = 4'h3,
    EL_ATOM_E    = 4'h4,
    EL_ATOM_N    = 4'h5,
    EL_CANCEL    = 4'h6,
    EL_EXCEPTION = 4'h7,
    EL_COMMIT    = 4'h8
  } elem_kind_t;

  // One trace element.
  typedef struct packed {
    elem_kind_t            kind;
    logic [`TE_ADDR_W-1:0] addr;
    logic [`TE_CTX_W-1:0]  ctx;
    logic [`TE_CNT_W-1:0]  count;
  } elem_t;

  // Sequencer phase, one-hot.
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_EMIT = 2'b10
  } phase_t;

  // Whole state of the element generator.
  typedef struct packed {
    phase_t                phase;
    logic                  ready;       // Registered copy of idle.
    logic                  out_valid;
    elem_t                 out;
    logic                  need_info;   // Start sequence still owes trace-info.
    logic                  need_on;     // Start sequence still owes trace-on.
    logic                  flush;       // Lazy context/address must go out now.
    logic                  ctx_lazy;    // Context element owed before next atom or exception.
    logic [`TE_CTX_W-1:0]  traced_ctx;  // Context the analyser believes in.
    logic                  ctx_written; // Context register written, not yet synced.
    logic [`TE_CTX_W-1:0]  pend_ctx;    // Value written, applied at the barrier.
    logic                  addr_lazy;   // Target address owed before next atom or exception.
    logic [`TE_ADDR_W-1:0] addr_val;
    logic                  ran;         // An instruction ran at the owed address.
    logic                  pend_cancel;
    logic [`TE_CNT_W-1:0]  cancel_cnt;
    logic                  pend_main;
    elem_t                 main;
    logic                  post_sync;   // Main element is a barrier atom.
    logic                  post_exc;    // Main element is an exception.
    logic [`TE_ADDR_W-1:0] exc_vec;
    logic [`TE_CTX_W-1:0]  exc_ctx;
  } state_t;

  // State of the uncommitted window counter.
  typedef struct packed {
    logic [`TE_CNT_W-1:0] count;
  } win_state_t;

endpackage

// file: core/spec_window.sv
// Counter of emitted waypoint and exception elements not yet committed or cancelled.
// Assumes the caller never asks to remove more than it holds.
`timescale 1ns/100ps
`include "trace_elem_regs.svh"

module spec_window (
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_inc,
  input  wire logic                 i_dec,
  input  wire logic [`TE_CNT_W-1:0] i_dec_amt,
  output logic      [`TE_CNT_W-1:0] o_count
);

  trace_elem_pkg::win_state_t st_reg;  // Registered state.
  trace_elem_pkg::win_state_t st_next; // Next state.

  // Adds one per new element and removes the resolved amount. The caller
  // emits one element per cycle, so both never happen together.
  always_comb begin
    st_next = st_reg;
    if (i_inc) begin
      st_next.count = st_reg.count + `TE_CNT_ONE;
    end else if (i_dec) begin
      st_next.count = st_reg.count - i_dec_amt;
    end
  end

  // Registers the window state.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_count = st_reg.count;

endmodule

// file: core/trace_elem_gen.sv
// Program-flow trace element generator: turns processing element events into
// an ordered element stream for a trace analyser.
// Assumes the processing element holds an event until o_ready is seen high.
// Contract
// - start emits info, on, context, address
// - taken waypoint branch emits taken atom
// - not-taken conditional branch emits not-taken atom
// - atom implies all untraced instructions before it
// - non-waypoint instructions emit no element
// - cancel emits count of discarded waypoint elements
// - abort emits cancel, then exception at fault
// - exception address implies all earlier instructions ran
// - back-to-back exception emits address then exception
// - commit count equals oldest now-committed elements
// - context writes traced as old until sync
// - context sync barrier emits taken atom
// - context element precedes execution in new context
// - exception followed by its target address element
`timescale 1ns/100ps
`include "trace_elem_regs.svh"

module trace_elem_gen (
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire trace_elem_pkg::evt_t  i_evt,
  output logic                       o_ready,
  output logic                       o_elem_valid,
  output trace_elem_pkg::elem_t      o_elem
);

  trace_elem_pkg::state_t st_reg;      // Registered state.
  trace_elem_pkg::state_t st_next;     // Next state.
  logic [`TE_CNT_W-1:0]   outstanding; // Uncommitted elements in the window.
  logic                   win_inc;     // One atom or exception emitted.
  logic                   win_dec;     // Cancel or commit emitted.
  logic [`TE_CNT_W-1:0]   win_amt;     // How many leave the window.
  logic                   accept;      // Event taken this cycle.
  logic [`TE_CNT_W-1:0]   clamp;       // Scratch count limited to the window.
  logic                   busy;        // Work left after this cycle.
  logic                   main_exec;   // Pending main element reports execution.

  assign accept = st_reg.ready && i_evt.valid;

  // A commit reports no execution, so an owed context or target address
  // waits for the next atom or exception instead of going out before it.
  assign main_exec = st_reg.pend_main && (st_reg.main.kind != trace_elem_pkg::EL_COMMIT);

  // The window count lives in its own counter so cancel and commit can be
  // limited to what was really emitted.
  spec_window spec_window_i (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_inc     (win_inc),
    .i_dec     (win_dec),
    .i_dec_amt (win_amt),
    .o_count   (outstanding)
  );

  // One element leaves per cycle in strict priority, so the analyser sees a
  // single program-ordered stream and counts land on the right elements.
  always_comb begin
    st_next           = st_reg;
    st_next.out_valid = 1'b0;
    win_inc           = 1'b0;
    win_dec           = 1'b0;
    win_amt           = '0;
    clamp             = '0;
    if (st_reg.phase == trace_elem_pkg::PH_EMIT) begin
      st_next.out_valid = 1'b1;
      st_next.out       = '0;
      if (st_reg.need_info) begin
        st_next.out.kind  = trace_elem_pkg::EL_INFO;
        st_next.need_info = 1'b0;
      end else if (st_reg.need_on) begin
        st_next.out.kind = trace_elem_pkg::EL_ON;
        st_next.need_on  = 1'b0;
      end else if (st_reg.pend_cancel) begin
        // Cancel goes ahead of the abort exception; never beyond the window.
        clamp = (st_reg.cancel_cnt > outstanding) ? outstanding : st_reg.cancel_cnt;
        st_next.out.kind    = trace_elem_pkg::EL_CANCEL;
        st_next.out.count   = clamp;
        st_next.pend_cancel = 1'b0;
        win_dec             = 1'b1;
        win_amt             = clamp;
      end else if (st_reg.ctx_lazy && (main_exec || st_reg.flush)) begin
        st_next.out.kind = trace_elem_pkg::EL_CONTEXT;
        st_next.out.ctx  = st_reg.traced_ctx;
        st_next.ctx_lazy = 1'b0;
      end else if (st_reg.addr_lazy && (main_exec || st_reg.flush)) begin
        st_next.out.kind  = trace_elem_pkg::EL_ADDRESS;
        st_next.out.addr  = st_reg.addr_val;
        st_next.addr_lazy = 1'b0;
      end else if (st_reg.pend_main) begin
        st_next.out       = st_reg.main;
        st_next.pend_main = 1'b0;
        if (st_reg.main.kind == trace_elem_pkg::EL_COMMIT) begin
          // A zero or oversized count commits everything outstanding.
          clamp = ((st_reg.main.count == `TE_CNT_ALL) || (st_reg.main.count > outstanding))
                  ? outstanding : st_reg.main.count;
          st_next.out.count = clamp;
          win_dec           = 1'b1;
          win_amt           = clamp;
        end else begin
          win_inc = 1'b1;
        end
        if (st_reg.post_sync && st_reg.ctx_written) begin
          // The barrier atom still belongs to the old context; the new one
          // is announced before the next atom or exception that follows it.
          st_next.traced_ctx  = st_reg.pend_ctx;
          st_next.ctx_lazy    = 1'b1;
          st_next.ctx_written = 1'b0;
        end
        if (st_reg.post_exc) begin
          // Execution resumes at the vector, which is owed as an address.
          st_next.addr_lazy   = 1'b1;
          st_next.addr_val    = st_reg.exc_vec;
          st_next.ran         = 1'b0;
          st_next.ctx_lazy    = st_reg.ctx_lazy || (st_reg.exc_ctx != st_reg.traced_ctx);
          st_next.traced_ctx  = st_reg.exc_ctx;
          st_next.ctx_written = 1'b0;
        end
        st_next.post_sync = 1'b0;
        st_next.post_exc  = 1'b0;
      end
      if (!st_next.ctx_lazy && !st_next.addr_lazy) begin
        st_next.flush = 1'b0;
      end
    end else if (accept) begin
      st_next.main = '0;
      case (i_evt.kind)
        trace_elem_pkg::EV_START: begin
          st_next.need_info   = 1'b1;
          st_next.need_on     = 1'b1;
          st_next.flush       = 1'b1;
          st_next.ctx_lazy    = 1'b1;
          st_next.traced_ctx  = i_evt.ctx;
          st_next.addr_lazy   = 1'b1;
          st_next.addr_val    = i_evt.addr;
          st_next.ctx_written = 1'b0;
        end
        trace_elem_pkg::EV_BR_TAKEN: begin
          // The atom stands for every untraced instruction before it.
          st_next.pend_main = 1'b1;
          st_next.main.kind = trace_elem_pkg::EL_ATOM_E;
        end
        trace_elem_pkg::EV_BR_NOT_TAKEN: begin
          st_next.pend_main = 1'b1;
          st_next.main.kind = trace_elem_pkg::EL_ATOM_N;
        end
        trace_elem_pkg::EV_SYNC_BARRIER: begin
          st_next.pend_main = 1'b1;
          st_next.main.kind = trace_elem_pkg::EL_ATOM_E;
          st_next.post_sync = 1'b1;
        end
        trace_elem_pkg::EV_PLAIN: begin
          st_next.ran = 1'b1;
        end
        trace_elem_pkg::EV_CTX_WRITE: begin
          // Held back so later instructions still trace in the old context.
          st_next.ran         = 1'b1;
          st_next.ctx_written = 1'b1;
          st_next.pend_ctx    = i_evt.ctx;
        end
        trace_elem_pkg::EV_CANCEL: begin
          st_next.pend_cancel = (i_evt.count != '0) && (outstanding != '0);
          st_next.cancel_cnt  = i_evt.count;
        end
        trace_elem_pkg::EV_ABORT: begin
          // Fault address re-implies the instructions the cancel removed.
          st_next.pend_cancel = (i_evt.count != '0) && (outstanding != '0);
          st_next.cancel_cnt  = i_evt.count;
          st_next.pend_main   = 1'b1;
          st_next.main.kind   = trace_elem_pkg::EL_EXCEPTION;
          st_next.main.addr   = i_evt.addr;
          st_next.post_exc    = 1'b1;
          st_next.exc_vec     = i_evt.vector;
          st_next.exc_ctx     = i_evt.ctx;
        end
        trace_elem_pkg::EV_EXCEPTION: begin
          // Nothing ran at the previous vector: report the vector itself.
          st_next.pend_main = 1'b1;
          st_next.main.kind = trace_elem_pkg::EL_EXCEPTION;
          st_next.main.addr = (st_reg.addr_lazy && !st_reg.ran)
                              ? st_reg.addr_val : i_evt.addr;
          st_next.post_exc  = 1'b1;
          st_next.exc_vec   = i_evt.vector;
          st_next.exc_ctx   = i_evt.ctx;
        end
        trace_elem_pkg::EV_COMMIT: begin
          st_next.pend_main  = 1'b1;
          st_next.main.kind  = trace_elem_pkg::EL_COMMIT;
          st_next.main.count = i_evt.count;
        end
        default: begin
          st_next.pend_main = 1'b0;
        end
      endcase
    end
    busy = st_next.need_info || st_next.need_on || st_next.pend_cancel || st_next.pend_main
           || (st_next.flush && (st_next.ctx_lazy || st_next.addr_lazy));
    st_next.phase = busy ? trace_elem_pkg::PH_EMIT : trace_elem_pkg::PH_IDLE;
    st_next.ready = !busy;
  end

  // Registers the whole state; ready comes up one cycle after reset release.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg       <= '0;
      st_reg.phase <= trace_elem_pkg::PH_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_ready      = st_reg.ready;
  assign o_elem_valid = st_reg.out_valid;
  assign o_elem       = st_reg.out;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // Emits of a given kind.
  function automatic logic is_el(trace_elem_pkg::elem_kind_t k);
    is_el = o_elem_valid && (o_elem.kind == k);
  endfunction

  sequence s_start;
    is_el(trace_elem_pkg::EL_INFO) ##1 is_el(trace_elem_pkg::EL_ON)
    ##1 is_el(trace_elem_pkg::EL_CONTEXT)
    ##1 (is_el(trace_elem_pkg::EL_ADDRESS) && (o_elem.addr == $past(i_evt.addr, 5)));
  endsequence
  // The first element shows two edges after the event is taken.
  property p_start;
    accept && (i_evt.kind == trace_elem_pkg::EV_START) |=> ##1 s_start;
  endproperty
  a_start: assert property (p_start) else $error("start sequence wrong");

  property p_taken;
    accept && (i_evt.kind == trace_elem_pkg::EV_BR_TAKEN)
      |-> ##[1:4] is_el(trace_elem_pkg::EL_ATOM_E);
  endproperty
  a_taken: assert property (p_taken) else $error("taken atom missing");

  property p_not_taken;
    accept && (i_evt.kind == trace_elem_pkg::EV_BR_NOT_TAKEN)
      |-> ##[1:4] is_el(trace_elem_pkg::EL_ATOM_N);
  endproperty
  a_not_taken: assert property (p_not_taken) else $error("not-taken atom missing");

  property p_plain;
    accept && (i_evt.kind == trace_elem_pkg::EV_PLAIN) |=> !o_elem_valid ##1 !o_elem_valid;
  endproperty
  a_plain: assert property (p_plain) else $error("plain instruction emitted");

  property p_cancel;
    is_el(trace_elem_pkg::EL_CANCEL)
      |-> (o_elem.count != '0) && (outstanding == $past(outstanding) - o_elem.count);
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel count wrong");

  sequence s_abort;
    is_el(trace_elem_pkg::EL_CANCEL)
    ##1 (is_el(trace_elem_pkg::EL_EXCEPTION) && (o_elem.addr == $past(i_evt.addr, 3)));
  endsequence
  property p_abort;
    accept && (i_evt.kind == trace_elem_pkg::EV_ABORT) && (i_evt.count != '0)
      && (outstanding != '0) && !st_reg.ctx_lazy && !st_reg.addr_lazy |=> ##1 s_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort order wrong");

  property p_double_exc;
    accept && (i_evt.kind == trace_elem_pkg::EV_EXCEPTION) && st_reg.addr_lazy
      && !st_reg.ran && !st_reg.ctx_lazy
      |=> ##1 is_el(trace_elem_pkg::EL_ADDRESS)
          ##1 (is_el(trace_elem_pkg::EL_EXCEPTION) && (o_elem.addr == $past(o_elem.addr)));
  endproperty
  a_double_exc: assert property (p_double_exc) else $error("second exception wrong");

  property p_commit;
    is_el(trace_elem_pkg::EL_COMMIT)
      |-> ($past(outstanding) >= o_elem.count) && (outstanding == $past(outstanding) - o_elem.count);
  endproperty
  a_commit: assert property (p_commit) else $error("commit count wrong");

  property p_barrier_ctx;
    accept && (i_evt.kind == trace_elem_pkg::EV_SYNC_BARRIER) && st_reg.ctx_written
      && !st_reg.ctx_lazy && !st_reg.addr_lazy
      |=> ##1 is_el(trace_elem_pkg::EL_ATOM_E) && st_reg.ctx_lazy
          && (st_reg.traced_ctx == $past(st_reg.pend_ctx, 2));
  endproperty
  a_barrier_ctx: assert property (p_barrier_ctx) else $error("barrier context wrong");

  property p_exc_target;
    is_el(trace_elem_pkg::EL_EXCEPTION) |-> st_reg.addr_lazy && !st_reg.ran;
  endproperty
  a_exc_target: assert property (p_exc_target) else $error("target address not owed");

endmodule

// file: sim/pe_model.sv
// Behavioural processing element that feeds events into the trace element generator.
// Assumes one clock and that an event is taken at an edge where ready is high.
`timescale 1ns/100ps
`include "trace_elem_regs.svh"

module pe_model (
  input  wire logic                 i_clk,
  input  wire logic                 i_ready,
  output trace_elem_pkg::evt_t      o_evt
);
  logic ready_seen;  // Ready as the coming rising edge will see it.

  // Ready is registered, so its value at the falling edge is what the next rising edge samples.
  always @(negedge i_clk) begin
    ready_seen = i_ready;
  end

  // Nothing is presented before the bench asks for it.
  initial begin
    o_evt = '0;
  end

  // Present one event and hold it unchanged until an edge at which ready was high.
  task automatic send(input trace_elem_pkg::evt_kind_t kind,
                      input logic [`TE_ADDR_W-1:0] addr,
                      input logic [`TE_ADDR_W-1:0] vector,
                      input logic [`TE_CTX_W-1:0]  ctx,
                      input logic [`TE_CNT_W-1:0]  count);
    int                   waited;
    trace_elem_pkg::evt_t ev;
    ev.valid  = 1'b1;
    ev.kind   = kind;
    ev.addr   = addr;
    ev.vector = vector;
    ev.ctx    = ctx;
    ev.count  = count;
    @(posedge i_clk);
    o_evt <= ev;
    waited = 0;
    do begin
      @(posedge i_clk);
      waited++;
    end while (ready_seen !== 1'b1 && waited < 100);
    // Once taken the fields show the inverse, so a design reading stale fields goes wrong.
    ev       = ~ev;
    ev.valid = 1'b0;
    o_evt <= ev;
  endtask
endmodule

// file: sim/trace_elem_gen_tb.sv
// Self-checking bench for the trace element generator, with a processing element model.
// Assumes the package and the constants header are compiled first.
`timescale 1ns/100ps
`include "trace_elem_regs.svh"

module trace_elem_gen_tb;
  logic                  i_clk;         // 10 MHz clock.
  logic                  i_sys_rst;     // Active high reset.
  trace_elem_pkg::evt_t  evt;           // Events from the model.
  logic                  o_ready;       // Generator accepts an event.
  logic                  o_elem_valid;  // One element this cycle.
  trace_elem_pkg::elem_t o_elem;        // The element.
  trace_elem_pkg::elem_t seen_q[$];     // Elements in the order they left.
  int                    fail_count;    // Mismatches.
  int                    compares;      // Comparisons made.

  trace_elem_gen trace_elem_gen_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_evt(evt),
    .o_ready(o_ready), .o_elem_valid(o_elem_valid), .o_elem(o_elem));
  pe_model pe_model_i (.i_clk(i_clk), .i_ready(o_ready), .o_evt(evt));

  // The clock toggles every half period of 50 ns.
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // Elements stand one cycle, so the falling edge sees each one settled exactly once.
  always @(negedge i_clk) begin
    if (o_elem_valid === 1'b1) begin
      seen_q.push_back(o_elem);
    end
  end

  // Report one mismatch at once.
  task automatic err(input string msg);
    $display("ERROR at %0t: %s", $time, msg);
    fail_count++;
  endtask

  // Print the counts and the verdict, then stop.
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compare a single level against its expected value.
  task automatic check_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      err(what);
    end
  endtask

  // Take the next element from the stream, waiting a bounded time, and compare every field.
  task automatic check_el(input trace_elem_pkg::elem_kind_t k, input logic [31:0] a,
                          input logic [31:0] c, input logic [7:0] n);
    int                    waited;
    trace_elem_pkg::elem_t exp;
    trace_elem_pkg::elem_t got;
    waited = 0;
    while (seen_q.size() == 0 && waited < 40) begin
      @(negedge i_clk);
      waited++;
    end
    exp = {k, a, c, n};
    compares++;
    if (seen_q.size() == 0) begin
      err("expected element never came");
    end else begin
      got = seen_q.pop_front();
      if (got !== exp) begin
        $display("ERROR at %0t: element %h, expected %h", $time, got, exp);
        fail_count++;
      end
    end
  endtask

  // After a settling time no further element may have left.
  task automatic check_quiet();
    repeat (12) @(negedge i_clk);
    compares++;
    if (seen_q.size() != 0) begin
      err("unexpected extra element");
      seen_q.delete();
    end
  endtask

  // Shorthand for handing one event to the model.
  task automatic ev(input trace_elem_pkg::evt_kind_t k, input logic [31:0] a,
                    input logic [31:0] v, input logic [31:0] c, input logic [7:0] n);
    pe_model_i.send(k, a, v, c, n);
  endtask

  // Trace start, then a taken branch.
  task automatic sc_start();
    ev(trace_elem_pkg::EV_START, 32'h0000_1000, 32'h0, 32'h0000_00AA, 8'h00);
    check_el(trace_elem_pkg::EL_INFO, 32'h0, 32'h0, 8'h00);
    check_el(trace_elem_pkg::EL_ON, 32'h0, 32'h0, 8'h00);
    check_el(trace_elem_pkg::EL_CONTEXT, 32'h0, 32'h0000_00AA, 8'h00);
    check_el(trace_elem_pkg::EL_ADDRESS, 32'h0000_1000, 32'h0, 8'h00);
    ev(trace_elem_pkg::EV_BR_TAKEN, 32'h0, 32'h0, 32'h0, 8'h00);
    check_el(trace_elem_pkg::EL_ATOM_E, 32'h0, 32'h0, 8'h00);
    check_quiet();
  endtask

  // Plain instructions stay silent; the not-taken branch covers them.
  task automatic sc_plain_atoms();
    repeat (3) ev(trace_elem_pkg::EV_PLAIN, 32'h0, 32'h0, 32'h0, 8'h00);
    check_quiet();
    ev(trace_elem_pkg::EV_BR_NOT_TAKEN, 32'h0, 32'h0, 32'h0, 8'h00);
    check_el(trace_elem_pkg::EL_ATOM_N, 32'h0, 32'h0, 8'h00);
    check_quiet();
  endtask

  // Data abort, a second exception at once, then commit of all three elements.
  // The second exception's own return address must give way to the first vector.
  task automatic sc_abort_twice();
    ev(trace_elem_pkg::EV_ABORT, 32'h0000_2004, 32'h0000_4000, 32'h0000_00AA, 8'h01);
    check_el(trace_elem_pkg::EL_CANCEL, 32'h0, 32'h0, 8'h01);
    check_el(trace_elem_pkg::EL_EXCEPTION, 32'h0000_2004, 32'h0, 8'h00);
    ev(trace_elem_pkg::EV_EXCEPTION, 32'h0000_4004, 32'h0000_4800, 32'h0000_00AA, 8'h00);
    check_el(trace_elem_pkg::EL_ADDRESS, 32'h0000_4000, 32'h0, 8'h00);
    check_el(trace_elem_pkg::EL_EXCEPTION, 32'h0000_4000, 32'h0, 8'h00);
    ev(trace_elem_pkg::EV_COMMIT, 32'h0, 32'h0, 32'h0, 8'h00);
    check_el(trace_elem_pkg::EL_COMMIT, 32'h0, 32'h0, 8'h03);
    check_quiet();
  endtask

  // The owed vector address comes first; a cancel on an empty window says nothing.
  task automatic sc_cancel();
    ev(trace_elem_pkg::EV_BR_TAKEN, 32'h0, 32'h0, 32'h0, 8'h00);
    check_el(trace_elem_pkg::EL_ADDRESS, 32'h0000_4800, 32'h0, 8'h00);
    check_el(trace_elem_pkg::EL_ATOM_E, 32'h0, 32'h0, 8'h00);
    ev(trace_elem_pkg::EV_CANCEL, 32'h0, 32'h0, 32'h0, 8'h01);
    check_el(trace_elem_pkg::EL_CANCEL, 32'h0, 32'h0, 8'h01);
    ev(trace_elem_pkg::EV_CANCEL, 32'h0, 32'h0, 32'h0, 8'h01);
    check_quiet();
  endtask

  // Context write, barrier, exception into a third context, then a clamped commit.
  task automatic sc_context();
    ev(trace_elem_pkg::EV_CTX_WRITE, 32'h0, 32'h0, 32'h0000_00BB, 8'h00);
    ev(trace_elem_pkg::EV_BR_TAKEN, 32'h0, 32'h0, 32'h0, 8'h00);
    check_el(trace_elem_pkg::EL_ATOM_E, 32'h0, 32'h0, 8'h00);
    ev(trace_elem_pkg::EV_SYNC_BARRIER, 32'h0, 32'h0, 32'h0, 8'h00);
    check_el(trace_elem_pkg::EL_ATOM_E, 32'h0, 32'h0, 8'h00);
    ev(trace_elem_pkg::EV_PLAIN, 32'h0, 32'h0, 32'h0, 8'h00);
    ev(trace_elem_pkg::EV_EXCEPTION, 32'h0000_2010, 32'h0000_3000, 32'h0000_00CC, 8'h00);
    check_el(trace_elem_pkg::EL_CONTEXT, 32'h0, 32'h0000_00BB, 8'h00);
    check_el(trace_elem_pkg::EL_EXCEPTION, 32'h0000_2010, 32'h0, 8'h00);
    ev(trace_elem_pkg::EV_BR_TAKEN, 32'h0, 32'h0, 32'h0, 8'h00);
    check_el(trace_elem_pkg::EL_CONTEXT, 32'h0, 32'h0000_00CC, 8'h00);
    check_el(trace_elem_pkg::EL_ADDRESS, 32'h0000_3000, 32'h0, 8'h00);
    check_el(trace_elem_pkg::EL_ATOM_E, 32'h0, 32'h0, 8'h00);
    ev(trace_elem_pkg::EV_COMMIT, 32'h0, 32'h0, 32'h0, 8'h02);
    check_el(trace_elem_pkg::EL_COMMIT, 32'h0, 32'h0, 8'h02);
    ev(trace_elem_pkg::EV_COMMIT, 32'h0, 32'h0, 32'h0, 8'h09);
    check_el(trace_elem_pkg::EL_COMMIT, 32'h0, 32'h0, 8'h02);
    check_quiet();
  endtask

  // Reset for three cycles, then run the scenarios in order.
  initial begin
    fail_count = 0;
    compares   = 0;
    i_sys_rst  = 1'b1;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    check_bit(o_ready, 1'b0, "ready high in reset");
    check_bit(o_elem_valid, 1'b0, "element valid in reset");
    @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (2) @(negedge i_clk);
    check_bit(o_ready, 1'b1, "ready low after reset");
    sc_start();
    sc_plain_atoms();
    sc_abort_twice();
    sc_cancel();
    sc_context();
    close_out();
  end

  // A hang is cut short well beyond the few hundred cycles the scenarios need.
  initial begin
    repeat (6000) @(posedge i_clk);
    err("watchdog expired");
    close_out();
  end
endmodule
